// File: core/dtc_conv_ctrl.sv
`timescale 1ns/10ps
`default_nettype none
`include "dtc_defines.svh"

// What this block does
// R01: free-running needs standby pin high, bit 6 clear
// R02: one-shot command starts a single conversion
// R03: rate register selects automatic conversion interval
// R04: sources switched through both sensors, about 60 ms
// R05: results stored as 8-bit two's complement
// R06: compare results with limits, set status flags
// R07: out-of-limit result drives open-drain alert low
// R08: both channels measured, updated together on success
// R09: each result averages ten converter cycles
// R10: address pins decode low, high or open
// R11: address pins latched at each conversion start
// R12: no clock-low timeout on the bus side
// R13: bit 7 mask, bit 6 standby, reset clears
// R14: hardware standby ignores all; software standby allows one-shot (the code still stores register writes in hardware standby)
// R15: hardware standby aborts conversion, results unchanged
// R16: commands 00h/01h read local/remote, reset zero
module dtc_conv_ctrl #(
  parameter logic [31:0] MEAS_WINDOW_CYCLES = 32'(`DTC_MEAS_WINDOW_CYC),
  parameter logic [31:0] RATE_BASE_CYCLES = 32'(`DTC_RATE_BASE_CYC)
) (
  // clock and reset
  input wire logic clock,
  input wire logic rst,
  // pins
  input wire logic hwStandbyNPin,
  input wire logic [1:0] addrSelPinLo,
  input wire logic [1:0] addrSelPinHi,
  output logic alertOut,
  output logic alertOe,
  // command port from the serial interface
  input wire logic wrStrobe,
  input wire logic [7:0] wrCmd,
  input wire logic [7:0] wrData,
  input wire logic [7:0] rdCmd,
  output logic [7:0] rdData,
  // converter
  output logic adcStart,
  output logic adcSelRemote,
  output logic adcCurrentEn,
  input wire logic adcDone,
  input wire logic [7:0] adcSample,
  // state view
  output logic [6:0] busAddr,
  output logic convBusy,
  output logic [7:0] localTempResult,
  output logic [7:0] remoteTempResult
);

  if (MEAS_WINDOW_CYCLES < 32'h0000_0040 || RATE_BASE_CYCLES < 32'h0000_0100) begin : g_bad_params
    $error("dtc_conv_ctrl: window or rate base too short");
  end

  // divide by ten toward zero; exact for every sum of ten 8-bit samples
  function automatic logic [7:0] avgTen(input logic signed [11:0] sum);
    logic [11:0] mag;
    logic [27:0] prod;
    logic [7:0] quo;
    mag = sum[11] ? 12'(-sum) : 12'(sum);
    prod = {16'h0000, mag} * {12'h000, `DTC_DIV10_RECIP};
    quo = prod[23:16];
    avgTen = sum[11] ? 8'(-quo) : quo;
  endfunction

  // synchronised pins
  logic hwStandbyNSync;
  logic [1:0] addrLoSync;
  logic [1:0] addrHiSync;
  logic [6:0] addrDecoded;

  dtc_sync #(.WIDTH(5)) u_sync (
    .clock(clock),
    .rst(rst),
    .din({hwStandbyNPin, addrSelPinLo, addrSelPinHi}),
    .dout({hwStandbyNSync, addrLoSync, addrHiSync})
  );

  dtc_addr_decode u_addr (
    .loSense(addrLoSync),
    .hiSense(addrHiSync),
    .addr(addrDecoded)
  );

  // control state
  dtc_pkg::dtc_state_t state_r, state_nxt;
  logic [7:0] cfg_r, cfg_nxt;
  logic [7:0] rate_r, rate_nxt;
  dtc_pkg::dtc_limits_t limits_r, limits_nxt;
  dtc_pkg::dtc_status_t status_r, status_nxt;
  logic [7:0] localTemp_r, localTemp_nxt;
  logic [7:0] remoteTemp_r, remoteTemp_nxt;
  logic [6:0] busAddr_r, busAddr_nxt;
  logic addrSeeded_r, addrSeeded_nxt;
  logic [31:0] windowCnt_r, windowCnt_nxt;
  logic [31:0] rateCnt_r, rateCnt_nxt;
  logic [3:0] sampleCnt_r, sampleCnt_nxt;
  logic chanRemote_r, chanRemote_nxt;
  logic waitAdc_r, waitAdc_nxt;
  logic signed [11:0] accRemote_r, accRemote_nxt;
  logic signed [11:0] accLocal_r, accLocal_nxt;
  logic adcStart_r, adcStart_nxt;
  logic adcCurrentEn_r, adcCurrentEn_nxt;
  logic alertOe_r, alertOe_nxt;
  logic busy_r, busy_nxt;

  logic hwRun;
  logic freeRun;
  logic oneShot;
  logic [31:0] period;
  logic [2:0] rateCode;
  logic signed [11:0] sampleExt;

  always_comb begin
    hwRun = hwStandbyNSync;
    freeRun = hwRun && !cfg_r[`DTC_CFG_STANDBY_BIT]; // R01
    oneShot = wrStrobe && (wrCmd == `DTC_CMD_ONESHOT); // R02
    rateCode = (rate_r > `DTC_RATE_MAX_CODE) ? 3'h7 : rate_r[2:0];
    period = RATE_BASE_CYCLES >> rateCode; // R03
    sampleExt = {{4{adcSample[7]}}, adcSample};

    state_nxt = state_r;
    cfg_nxt = cfg_r;
    rate_nxt = rate_r;
    limits_nxt = limits_r;
    status_nxt = status_r;
    localTemp_nxt = localTemp_r;
    remoteTemp_nxt = remoteTemp_r;
    busAddr_nxt = busAddr_r;
    addrSeeded_nxt = 1'b1;
    windowCnt_nxt = windowCnt_r;
    rateCnt_nxt = rateCnt_r;
    sampleCnt_nxt = sampleCnt_r;
    chanRemote_nxt = chanRemote_r;
    waitAdc_nxt = waitAdc_r;
    accRemote_nxt = accRemote_r;
    accLocal_nxt = accLocal_r;
    adcStart_nxt = 1'b0;
    adcCurrentEn_nxt = 1'b0;
    busy_nxt = 1'b0;

    // the first cycle after reset loads the still-reset synchroniser output once, which decodes to address OO
    if (!addrSeeded_r) begin
      busAddr_nxt = addrDecoded;
    end

    // register writes; reserved configuration bits are not kept
    if (wrStrobe) begin
      case (wrCmd)
        `DTC_CMD_WR_CFG: cfg_nxt = wrData & `DTC_CFG_USED; // R13
        `DTC_CMD_WR_RATE: rate_nxt = wrData; // R03
        `DTC_CMD_WR_LHI: limits_nxt.localHigh = wrData;
        `DTC_CMD_WR_LLO: limits_nxt.localLow = wrData;
        `DTC_CMD_WR_RHI: limits_nxt.remoteHigh = wrData;
        `DTC_CMD_WR_RLO: limits_nxt.remoteLow = wrData;
        default: ;
      endcase
    end

    // interval runs start to start; it restarts whenever free-running stops
    if (!freeRun) begin
      rateCnt_nxt = 32'h0000_0000; // R01
    end else if (rateCnt_r < period - 32'h0000_0001) begin
      rateCnt_nxt = rateCnt_r + 32'h0000_0001;
    end

    case (state_r)
      dtc_pkg::ST_IDLE: begin
        // a one-shot while busy is dropped rather than queued
        if (hwRun && (oneShot || (freeRun && rateCnt_r >= period - 32'h0000_0001))) begin // R14
          state_nxt = dtc_pkg::ST_MEASURE;
          busAddr_nxt = addrDecoded; // R11
          rateCnt_nxt = 32'h0000_0000;
          windowCnt_nxt = 32'h0000_0000;
          sampleCnt_nxt = 4'h0;
          chanRemote_nxt = 1'b1;
          waitAdc_nxt = 1'b0;
          accRemote_nxt = 12'sh000;
          accLocal_nxt = 12'sh000;
          busy_nxt = 1'b1;
          adcCurrentEn_nxt = 1'b1;
        end
      end
      dtc_pkg::ST_MEASURE: begin
        busy_nxt = 1'b1;
        adcCurrentEn_nxt = 1'b1; // R04
        windowCnt_nxt = windowCnt_r + 32'h0000_0001;
        if (!hwRun || windowCnt_r >= MEAS_WINDOW_CYCLES - 32'h0000_0001) begin // R15
          // aborted or overrun: results stay as they were
          state_nxt = dtc_pkg::ST_IDLE; // R08
          busy_nxt = 1'b0;
          adcCurrentEn_nxt = 1'b0;
          waitAdc_nxt = 1'b0;
        end else if (!waitAdc_r) begin
          adcStart_nxt = 1'b1;
          waitAdc_nxt = 1'b1;
        end else if (adcDone) begin
          waitAdc_nxt = 1'b0;
          if (chanRemote_r) begin
            accRemote_nxt = accRemote_r + sampleExt; // R09
          end else begin
            accLocal_nxt = accLocal_r + sampleExt; // R09
          end
          if (sampleCnt_r == `DTC_AVG_COUNT - 4'h1) begin
            sampleCnt_nxt = 4'h0;
            if (chanRemote_r) begin
              chanRemote_nxt = 1'b0; // R04
            end else begin
              state_nxt = dtc_pkg::ST_STORE; // R08
              adcCurrentEn_nxt = 1'b0;
            end
          end else begin
            sampleCnt_nxt = sampleCnt_r + 4'h1;
          end
        end
      end
      dtc_pkg::ST_STORE: begin
        if (!hwRun) begin
          state_nxt = dtc_pkg::ST_IDLE; // R15
        end else begin
          busy_nxt = 1'b1;
          localTemp_nxt = avgTen(accLocal_r); // R05
          remoteTemp_nxt = avgTen(accRemote_r); // R08
          state_nxt = dtc_pkg::ST_COMPARE;
        end
      end
      dtc_pkg::ST_COMPARE: begin
        status_nxt.localHigh = $signed(localTemp_r) > $signed(limits_r.localHigh); // R06
        status_nxt.localLow = $signed(localTemp_r) < $signed(limits_r.localLow); // R06
        status_nxt.remoteHigh = $signed(remoteTemp_r) > $signed(limits_r.remoteHigh); // R06
        status_nxt.remoteLow = $signed(remoteTemp_r) < $signed(limits_r.remoteLow); // R06
        state_nxt = dtc_pkg::ST_IDLE;
      end
      default: begin
        state_nxt = dtc_pkg::ST_IDLE;
      end
    endcase

    // alert follows the stored flags, so it stays low until a clean result or until mask bit 7 is set
    alertOe_nxt = (|status_r) && !cfg_r[`DTC_CFG_MASK_BIT]; // R07 R13
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      state_r <= dtc_pkg::ST_IDLE;
      cfg_r <= `DTC_CFG_RESET; // R13
      rate_r <= `DTC_RATE_RESET;
      limits_r <= {`DTC_HI_LIMIT_RESET, `DTC_LO_LIMIT_RESET,
                   `DTC_HI_LIMIT_RESET, `DTC_LO_LIMIT_RESET};
      status_r <= '0;
      localTemp_r <= `DTC_TEMP_RESET; // R16
      remoteTemp_r <= `DTC_TEMP_RESET; // R16
      busAddr_r <= `DTC_ADDR_OO;
      addrSeeded_r <= 1'b0;
      windowCnt_r <= 32'h0000_0000;
      rateCnt_r <= 32'h0000_0000;
      sampleCnt_r <= 4'h0;
      chanRemote_r <= 1'b1;
      waitAdc_r <= 1'b0;
      accRemote_r <= 12'sh000;
      accLocal_r <= 12'sh000;
      adcStart_r <= 1'b0;
      adcCurrentEn_r <= 1'b0;
      alertOe_r <= 1'b0;
      busy_r <= 1'b0;
    end else begin
      state_r <= state_nxt;
      cfg_r <= cfg_nxt;
      rate_r <= rate_nxt;
      limits_r <= limits_nxt;
      status_r <= status_nxt;
      localTemp_r <= localTemp_nxt;
      remoteTemp_r <= remoteTemp_nxt;
      busAddr_r <= busAddr_nxt;
      addrSeeded_r <= addrSeeded_nxt;
      windowCnt_r <= windowCnt_nxt;
      rateCnt_r <= rateCnt_nxt;
      sampleCnt_r <= sampleCnt_nxt;
      chanRemote_r <= chanRemote_nxt;
      waitAdc_r <= waitAdc_nxt;
      accRemote_r <= accRemote_nxt;
      accLocal_r <= accLocal_nxt;
      adcStart_r <= adcStart_nxt;
      adcCurrentEn_r <= adcCurrentEn_nxt;
      alertOe_r <= alertOe_nxt;
      busy_r <= busy_nxt;
    end
  end

  // read path: no timer anywhere, a stalled host never resets it
  logic [7:0] rdData_r, rdData_nxt;

  always_comb begin
    case (rdCmd)
      `DTC_CMD_LOCAL: rdData_nxt = localTemp_r; // R16
      `DTC_CMD_REMOTE: rdData_nxt = remoteTemp_r; // R16
      `DTC_CMD_STATUS: rdData_nxt = {busy_r, status_r, 3'h0};
      `DTC_CMD_RD_CFG: rdData_nxt = cfg_r;
      `DTC_CMD_RD_RATE: rdData_nxt = rate_r;
      `DTC_CMD_RD_LHI: rdData_nxt = limits_r.localHigh;
      `DTC_CMD_RD_LLO: rdData_nxt = limits_r.localLow;
      `DTC_CMD_RD_RHI: rdData_nxt = limits_r.remoteHigh;
      `DTC_CMD_RD_RLO: rdData_nxt = limits_r.remoteLow;
      default: rdData_nxt = 8'h00;
    endcase
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      rdData_r <= 8'h00;
    end else begin
      rdData_r <= rdData_nxt; // R12
    end
  end

  // outputs; the alert pin only ever pulls low
  always_comb begin
    alertOut = 1'b0;
  end

  assign alertOe = alertOe_r;
  assign rdData = rdData_r;
  assign adcStart = adcStart_r;
  assign adcSelRemote = chanRemote_r;
  assign adcCurrentEn = adcCurrentEn_r;
  assign busAddr = busAddr_r;
  assign convBusy = busy_r;
  assign localTempResult = localTemp_r;
  assign remoteTempResult = remoteTemp_r;

endmodule

`default_nettype wire

// File: core/dtc_defines.svh
`ifndef DTC_DEFINES_SVH
`define DTC_DEFINES_SVH

// timing
`define DTC_CLK_HZ 40000000
`define DTC_MEAS_WINDOW_MS 60
`define DTC_MEAS_WINDOW_CYC ((64'(`DTC_MEAS_WINDOW_MS) * 64'(`DTC_CLK_HZ)) / 64'd1000)
`define DTC_RATE_BASE_MS 16000
`define DTC_RATE_BASE_CYC ((64'(`DTC_RATE_BASE_MS) * 64'(`DTC_CLK_HZ)) / 64'd1000)
`define DTC_RATE_MAX_CODE 8'h07

// averaging: ten samples, divide by ten through a 16-bit reciprocal
`define DTC_AVG_COUNT 4'hA
`define DTC_DIV10_RECIP 16'h199A

// command codes
`define DTC_CMD_LOCAL 8'h00
`define DTC_CMD_REMOTE 8'h01
`define DTC_CMD_STATUS 8'h02
`define DTC_CMD_RD_CFG 8'h03
`define DTC_CMD_RD_RATE 8'h04
`define DTC_CMD_RD_LHI 8'h05
`define DTC_CMD_RD_LLO 8'h06
`define DTC_CMD_RD_RHI 8'h07
`define DTC_CMD_RD_RLO 8'h08
`define DTC_CMD_WR_CFG 8'h09
`define DTC_CMD_WR_RATE 8'h0A
`define DTC_CMD_WR_LHI 8'h0B
`define DTC_CMD_WR_LLO 8'h0C
`define DTC_CMD_WR_RHI 8'h0D
`define DTC_CMD_WR_RLO 8'h0E
`define DTC_CMD_ONESHOT 8'h0F

// configuration fields and reset values
`define DTC_CFG_MASK_BIT 7
`define DTC_CFG_STANDBY_BIT 6
`define DTC_CFG_USED 8'hC0
`define DTC_CFG_RESET 8'h00
`define DTC_RATE_RESET 8'h02
`define DTC_TEMP_RESET 8'h00
`define DTC_HI_LIMIT_RESET 8'h7F
`define DTC_LO_LIMIT_RESET 8'hC9

// bus addresses by {lo pin, hi pin} level
`define DTC_ADDR_LL 7'h18
`define DTC_ADDR_LO 7'h19
`define DTC_ADDR_LH 7'h1A
`define DTC_ADDR_OL 7'h29
`define DTC_ADDR_OO 7'h2A
`define DTC_ADDR_OH 7'h2B
`define DTC_ADDR_HL 7'h4C
`define DTC_ADDR_HO 7'h4D
`define DTC_ADDR_HH 7'h4E

`endif

// File: core/dtc_pkg.sv
`default_nettype none

package dtc_pkg;

  typedef enum logic [3:0] {
    ST_IDLE = 4'b0001,
    ST_MEASURE = 4'b0010,
    ST_STORE = 4'b0100,
    ST_COMPARE = 4'b1000
  } dtc_state_t;

  typedef enum logic [1:0] {
    LVL_LOW = 2'h0,
    LVL_OPEN = 2'h1,
    LVL_HIGH = 2'h2
  } dtc_level_t;

  typedef struct packed {
    logic signed [7:0] localHigh;
    logic signed [7:0] localLow;
    logic signed [7:0] remoteHigh;
    logic signed [7:0] remoteLow;
  } dtc_limits_t;

  typedef struct packed {
    logic localHigh;
    logic localLow;
    logic remoteHigh;
    logic remoteLow;
  } dtc_status_t;

endpackage

`default_nettype wire

// File: core/dtc_sync.sv
`timescale 1ns/10ps
`default_nettype none

module dtc_sync #(
  parameter int WIDTH = 1
) (
  // clock and reset
  input wire logic clock,
  input wire logic rst,
  // levels
  input wire logic [WIDTH-1:0] din,
  output logic [WIDTH-1:0] dout
);

  logic [WIDTH-1:0] meta_r;
  logic [WIDTH-1:0] meta_nxt;
  logic [WIDTH-1:0] dout_nxt;

  if (WIDTH < 1) begin : g_bad_width
    $error("dtc_sync: width must be at least one");
  end

  always_comb begin
    meta_nxt = din;
    dout_nxt = meta_r;
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      meta_r <= '0;
      dout <= '0;
    end else begin
      meta_r <= meta_nxt;
      dout <= dout_nxt;
    end
  end

endmodule

`default_nettype wire

// File: core/dtc_addr_decode.sv
`timescale 1ns/10ps
`default_nettype none
`include "dtc_defines.svh"

module dtc_addr_decode (
  // comparator senses per pin: bit1 above high threshold, bit0 below low threshold
  input wire logic [1:0] loSense,
  input wire logic [1:0] hiSense,
  // decoded address
  output logic [6:0] addr
);

  function automatic dtc_pkg::dtc_level_t pinLevel(input logic [1:0] sense);
    if (sense[0]) begin
      pinLevel = dtc_pkg::LVL_LOW;
    end else if (sense[1]) begin
      pinLevel = dtc_pkg::LVL_HIGH;
    end else begin
      pinLevel = dtc_pkg::LVL_OPEN;
    end
  endfunction

  dtc_pkg::dtc_level_t loLvl;
  dtc_pkg::dtc_level_t hiLvl;

  always_comb begin
    loLvl = pinLevel(loSense); // R10
    hiLvl = pinLevel(hiSense); // R10
    case ({loLvl, hiLvl})
      {dtc_pkg::LVL_LOW, dtc_pkg::LVL_LOW}: addr = `DTC_ADDR_LL;
      {dtc_pkg::LVL_LOW, dtc_pkg::LVL_OPEN}: addr = `DTC_ADDR_LO;
      {dtc_pkg::LVL_LOW, dtc_pkg::LVL_HIGH}: addr = `DTC_ADDR_LH;
      {dtc_pkg::LVL_OPEN, dtc_pkg::LVL_LOW}: addr = `DTC_ADDR_OL;
      {dtc_pkg::LVL_OPEN, dtc_pkg::LVL_HIGH}: addr = `DTC_ADDR_OH;
      {dtc_pkg::LVL_HIGH, dtc_pkg::LVL_LOW}: addr = `DTC_ADDR_HL;
      {dtc_pkg::LVL_HIGH, dtc_pkg::LVL_OPEN}: addr = `DTC_ADDR_HO;
      {dtc_pkg::LVL_HIGH, dtc_pkg::LVL_HIGH}: addr = `DTC_ADDR_HH;
      default: addr = `DTC_ADDR_OO;
    endcase
  end

endmodule

`default_nettype wire

// File: tb/dtc_conv_ctrl_asserts.sv
`timescale 1ns/10ps
`default_nettype none

module dtc_conv_ctrl_asserts #(
  parameter logic [31:0] MEAS_WINDOW_CYCLES = 32'h0000_0800,
  parameter logic [31:0] RATE_BASE_CYCLES = 32'h0000_1000
) (
  // clock and reset
  input wire logic clock,
  input wire logic rst,
  // pins
  input wire logic hwStandbyNPin,
  input wire logic [1:0] addrSelPinLo,
  input wire logic [1:0] addrSelPinHi,
  input wire logic alertOut,
  input wire logic alertOe,
  // command port
  input wire logic wrStrobe,
  input wire logic [7:0] wrCmd,
  input wire logic [7:0] wrData,
  input wire logic [7:0] rdCmd,
  input wire logic [7:0] rdData,
  // converter
  input wire logic adcStart,
  input wire logic adcSelRemote,
  input wire logic adcCurrentEn,
  input wire logic adcDone,
  input wire logic [7:0] adcSample,
  // state view
  input wire logic [6:0] busAddr,
  input wire logic convBusy,
  input wire logic [7:0] localTempResult,
  input wire logic [7:0] remoteTempResult
);
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (rst);

  a_alert_open_drain: assert property (alertOut == 1'b0)
    else $error("alert pin drives high");
  a_start_in_conv: assert property (adcStart |-> convBusy && adcCurrentEn)
    else $error("sample request outside measurement");
  a_start_one_cycle: assert property (adcStart |=> !adcStart)
    else $error("sample request longer than one cycle");
  a_conv_opens_remote: assert property ($rose(convBusy) |-> adcSelRemote ##1 adcStart)
    else $error("conversion did not open on remote channel");
  // pin sync adds latency, so the abort is judged after six low samples
  a_hw_standby_idle: assert property ((!hwStandbyNPin)[*6] |-> !convBusy)
    else $error("conversion runs in hardware standby");
  a_temp_on_done: assert property (
    $changed(localTempResult) || $changed(remoteTempResult) |-> $past(convBusy, 2))
    else $error("result changed outside a conversion");
  a_addr_at_start: assert property (!$past(rst) && $changed(busAddr) |-> $rose(convBusy))
    else $error("address latched outside conversion start");
  a_oneshot_start: assert property (wrStrobe && wrCmd == 8'h0F && hwStandbyNPin
    && $past(hwStandbyNPin) && $past(hwStandbyNPin, 2) && !convBusy && !$past(convBusy)
    && !$past(convBusy, 2) && !$past(convBusy, 3) |=> convBusy)
    else $error("single conversion command not started");
  a_rd_local: assert property ($past(rdCmd) == 8'h00 |-> rdData == $past(localTempResult))
    else $error("local read mismatch");
  a_rd_remote: assert property ($past(rdCmd) == 8'h01 |-> rdData == $past(remoteTempResult))
    else $error("remote read mismatch");

  c_conv_done: cover property ($fell(convBusy));
  c_alert_on: cover property ($rose(alertOe));
  c_abort: cover property ($fell(convBusy) && !hwStandbyNPin);
endmodule

bind dtc_conv_ctrl dtc_conv_ctrl_asserts #(.MEAS_WINDOW_CYCLES(MEAS_WINDOW_CYCLES),
  .RATE_BASE_CYCLES(RATE_BASE_CYCLES)) u_chk (.clock(clock), .rst(rst),
  .hwStandbyNPin(hwStandbyNPin), .addrSelPinLo(addrSelPinLo), .addrSelPinHi(addrSelPinHi),
  .alertOut(alertOut), .alertOe(alertOe), .wrStrobe(wrStrobe), .wrCmd(wrCmd),
  .wrData(wrData), .rdCmd(rdCmd), .rdData(rdData), .adcStart(adcStart),
  .adcSelRemote(adcSelRemote), .adcCurrentEn(adcCurrentEn), .adcDone(adcDone),
  .adcSample(adcSample), .busAddr(busAddr), .convBusy(convBusy),
  .localTempResult(localTempResult), .remoteTempResult(remoteTempResult));
`default_nettype wire

// File: tb/dtc_adc_model.sv
`timescale 1ns/10ps
`default_nettype none

module dtc_adc_model (
  // clock and reset
  input wire logic clock,
  input wire logic rst,
  // converter side
  input wire logic adcStart,
  input wire logic adcSelRemote,
  input wire logic adcCurrentEn,
  output logic adcDone,
  output logic [7:0] adcSample,
  // scene
  input wire logic [7:0] remBase,
  input wire logic [7:0] locBase,
  input wire logic [3:0] lat
);
  logic [3:0] pend;
  int idx;
  // each sample adds idx mod 10, so the average must truncate toward zero
  always @(posedge clock or posedge rst) begin
    if (rst) begin
      adcDone <= 1'b0;
      adcSample <= 8'h00;
      pend <= 4'h0;
      idx <= 0;
    end else begin
      adcDone <= 1'b0;
      if (!adcCurrentEn) idx <= 0;
      if (adcStart) begin
        pend <= lat;
      end else if (pend > 4'h1) begin
        pend <= pend - 4'h1;
      end else if (pend == 4'h1) begin
        pend <= 4'h0;
        adcDone <= 1'b1;
        adcSample <= (adcSelRemote ? remBase : locBase) + 8'(idx % 10);
        idx <= idx + 1;
      end else begin
        // data is not valid between samples: keep it moving
        adcSample <= ~adcSample;
      end
    end
  end
endmodule
`default_nettype wire

// File: tb/test_dtc_conv_ctrl.sv
`timescale 1ns/10ps
`default_nettype none

module test_dtc_conv_ctrl;
  logic clock = 1'b0, rst = 1'b1, hwStandbyNPin = 1'b1, wrStrobe = 1'b0;
  logic [1:0] addrSelPinLo = 2'b01, addrSelPinHi = 2'b01;
  logic [7:0] wrCmd = 8'h00, wrData = 8'h00, rdCmd = 8'h00, rdData, adcSample;
  logic [7:0] remBase = 8'hEC, locBase = 8'h1E, localTempResult, remoteTempResult;
  logic [3:0] lat = 4'h2;
  logic alertOut, alertOe, adcStart, adcSelRemote, adcCurrentEn, adcDone, convBusy;
  logic [6:0] busAddr;
  int errorCnt = 0, nChecks = 0;

  always #12.5 clock = ~clock;

  dtc_conv_ctrl #(.MEAS_WINDOW_CYCLES(32'h0000_07D0), .RATE_BASE_CYCLES(32'h0000_1000)) i_dut (
    .clock(clock), .rst(rst), .hwStandbyNPin(hwStandbyNPin), .addrSelPinLo(addrSelPinLo),
    .addrSelPinHi(addrSelPinHi), .alertOut(alertOut), .alertOe(alertOe), .wrStrobe(wrStrobe),
    .wrCmd(wrCmd), .wrData(wrData), .rdCmd(rdCmd), .rdData(rdData), .adcStart(adcStart),
    .adcSelRemote(adcSelRemote), .adcCurrentEn(adcCurrentEn), .adcDone(adcDone),
    .adcSample(adcSample), .busAddr(busAddr), .convBusy(convBusy),
    .localTempResult(localTempResult), .remoteTempResult(remoteTempResult));

  dtc_adc_model i_adc (.clock(clock), .rst(rst), .adcStart(adcStart),
    .adcSelRemote(adcSelRemote), .adcCurrentEn(adcCurrentEn), .adcDone(adcDone),
    .adcSample(adcSample), .remBase(remBase), .locBase(locBase), .lat(lat));

  task automatic wrapUp;
    $display("checks %0d mismatches %0d", nChecks, errorCnt);
    if (errorCnt == 0 && nChecks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    nChecks++;
    if (got !== exp) begin
      errorCnt++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [7:0] cmd, input logic [7:0] data);
    @(negedge clock);
    wrStrobe = 1'b1;
    wrCmd = cmd;
    wrData = data;
    @(negedge clock);
    wrStrobe = 1'b0;
  endtask

  task automatic rd(input logic [7:0] cmd, input logic [7:0] exp);
    @(negedge clock);
    rdCmd = cmd;
    @(negedge clock);
    chk(16'(rdData), 16'(exp));
  endtask

  task automatic waitIdle;
    int k;
    k = 0;
    while (convBusy !== 1'b0 && k < 3000) begin
      @(negedge clock);
      k++;
    end
    if (k >= 3000) chk(16'h0001, 16'h0000);
    repeat (4) @(negedge clock);
  endtask

  task automatic t_reset;
    rd(8'h03, 8'h00);
    rd(8'h04, 8'h02);
    rd(8'h05, 8'h7F);
    rd(8'h06, 8'hC9);
    rd(8'h07, 8'h7F);
    rd(8'h08, 8'hC9);
    rd(8'h00, 8'h00);
    rd(8'h01, 8'h00);
    chk(16'(alertOe), 16'h0000);
    wr(8'h09, 8'h40);
    waitIdle();
    $display("test reset done");
  endtask

  task automatic t_oneshot;
    wr(8'h0F, 8'h00);
    waitIdle();
    rd(8'h00, 8'h22);
    rd(8'h01, 8'hF1);
    rd(8'h02, 8'h00);
    chk(16'(busAddr), 16'h0018);
    $display("test oneshot done");
  endtask

  task automatic t_alert;
    addrSelPinLo = 2'b10;
    addrSelPinHi = 2'b00;
    wr(8'h0B, 8'h20);
    wr(8'h0C, 8'h28);
    wr(8'h0D, 8'hE0);
    wr(8'h0E, 8'hF8);
    wr(8'h0F, 8'h00);
    waitIdle();
    chk(16'(alertOe), 16'h0001);
    rd(8'h02, 8'h78);
    rd(8'h08, 8'hF8);
    chk(16'(busAddr), 16'h004D);
    wr(8'h09, 8'hC0);
    repeat (2) @(negedge clock);
    chk(16'(alertOe), 16'h0000);
    rd(8'h03, 8'hC0);
    wr(8'h09, 8'h40);
    $display("test alert done");
  endtask

  task automatic t_hw_standby;
    hwStandbyNPin = 1'b0;
    repeat (4) @(negedge clock);
    wr(8'h0F, 8'h00);
    repeat (50) @(negedge clock);
    chk(16'(convBusy), 16'h0000);
    hwStandbyNPin = 1'b1;
    remBase = 8'h0A;
    repeat (4) @(negedge clock);
    wr(8'h0F, 8'h00);
    repeat (20) @(negedge clock);
    hwStandbyNPin = 1'b0;
    repeat (8) @(negedge clock);
    chk(16'(convBusy), 16'h0000);
    rd(8'h01, 8'hF1);
    hwStandbyNPin = 1'b1;
    repeat (4) @(negedge clock);
    $display("test hw standby done");
  endtask

  task automatic t_freerun;
    int k;
    lat = 4'h6;
    wr(8'h0A, 8'h03);
    wr(8'h09, 8'h00);
    k = 0;
    while (convBusy !== 1'b1 && k < 3000) begin
      @(negedge clock);
      k++;
    end
    k = 0;
    while (convBusy !== 1'b0 && k < 3000) begin
      @(negedge clock);
      k++;
    end
    while (convBusy !== 1'b1 && k < 3000) begin
      @(negedge clock);
      k++;
    end
    chk(16'(k), 16'h0200);
    waitIdle();
    rd(8'h01, 8'h0E);
    wr(8'h09, 8'h40);
    // a free-running start after standby would pick up the new remote level
    remBase = 8'h32;
    repeat (600) @(negedge clock);
    rd(8'h01, 8'h0E);
    $display("test free run done");
  endtask

  initial begin
    repeat (5) @(negedge clock);
    rst = 1'b0;
    repeat (3) @(negedge clock);
    t_reset();
    t_oneshot();
    t_alert();
    t_hw_standby();
    t_freerun();
    wrapUp();
  end

  // the tests need well under 10000 cycles; hanging waits are cut here
  initial begin
    #500000;
    errorCnt++;
    wrapUp();
  end
endmodule
`default_nettype wire
